// ==== hw/sdd_pkg.sv ====
// Constants, register map and mode encoding for the sigma-delta DAC control.
// Assumes a 32-bit AXI4-Lite slave; registers sit at byte address = index * 4.
package sdd_pkg;

  localparam int           AXI_ADDR_W = 8;
  localparam int           AXI_DATA_W = 32;
  localparam int           IDX_W      = 6;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_ANALOG_CONFIG  = 6'h03;
  localparam logic [IDX_W-1:0] IDX_DAC_CODE_VALUE = 6'h0A;
  localparam logic [IDX_W-1:0] IDX_SHADOW         = 6'h0B;
  localparam logic [IDX_W-1:0] IDX_WDCFG          = 6'h0C;
  localparam logic [IDX_W-1:0] IDX_INTST          = 6'h0D;
  localparam logic [IDX_W-1:0] IDX_INTMSK         = 6'h0E;
  localparam logic [IDX_W-1:0] IDX_STATE          = 6'h0F;

  localparam int           CONFIG_W              = 8;
  localparam logic [7:0]   CONFIG_RESET          = 8'hFD;
  localparam int           MODULATOR_DISABLE_BIT = 0;

  localparam int           VALUE_W       = 24;
  localparam int           CODE_W        = 17;
  localparam int           CODE_LSB      = 7;
  localparam logic [23:0]  VALUE_RESET   = 24'h000000;

  localparam int           KICK_W     = 2;
  localparam logic [1:0]   KICK_OFF   = 2'h0;
  localparam logic [1:0]   KICK_PIN   = 2'h1;
  localparam logic [1:0]   KICK_VALUE = 2'h2;

  localparam int           INT_W           = 3;
  localparam int           INT_CLKFAIL     = 0;
  localparam int           INT_KICK        = 1;
  localparam int           INT_CONFIG_REFUSED = 2;

  localparam logic [1:0]   RESP_OKAY   = 2'h0;
  localparam logic [1:0]   RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_OFF      = 2'b00,
    MODE_RUN      = 2'b01,
    MODE_FALLBACK = 2'b10
  } sdd_mode_e;

endpackage

// ==== hw/sdd_modulator.sv ====
// First-order sigma-delta modulator: one bit per clock, density code/2^W.
// Assumes the code is stable or changes only between clocks.
`timescale 1ns/1ps
module sdd_modulator #(
  parameter int CODE_W = 17
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              run,
  input  wire logic [CODE_W-1:0] code,
  output logic                   bit_out
);
  import sdd_pkg::*;

  if (CODE_W < 2 || CODE_W > 31) begin : g_bad_width
    $error("sdd_modulator: CODE_W out of range");
  end

  logic [CODE_W-1:0] acc;
  logic [CODE_W-1:0] next_acc;
  logic              next_bit_out;
  logic [CODE_W:0]   sum;

  always_comb begin
    sum          = {1'b0, acc} + {1'b0, code};
    next_acc     = sum[CODE_W-1:0];
    next_bit_out = sum[CODE_W];
    // Restart from zero so a fresh enable gives a repeatable stream
    if (!run) begin
      next_acc     = '0;
      next_bit_out = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc     <= '0;
      bit_out <= 1'b0;
    end else begin
      acc     <= next_acc;
      bit_out <= next_bit_out;
    end
  end

endmodule // sdd_modulator

// ==== hw/sdd_top.sv ====
// Sigma-delta DAC control: AXI4-Lite registers, modulator, clock-fail fallback.
// Assumes clk_fail, fallback_level and kick_pin are synchronous to aclk;
// dac_out high selects the reference level, low selects 0 V.
`timescale 1ns/1ps
module sdd_top (
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  input  wire logic [sdd_pkg::AXI_ADDR_W-1:0]  awaddr,
  input  wire logic [2:0]                      awprot,
  input  wire logic                            awvalid,
  output logic                                 awready,
  input  wire logic [sdd_pkg::AXI_DATA_W-1:0]  wdata,
  input  wire logic [3:0]                      wstrb,
  input  wire logic                            wvalid,
  output logic                                 wready,
  output logic [1:0]                           bresp,
  output logic                                 bvalid,
  input  wire logic                            bready,
  input  wire logic [sdd_pkg::AXI_ADDR_W-1:0]  araddr,
  input  wire logic [2:0]                      arprot,
  input  wire logic                            arvalid,
  output logic                                 arready,
  output logic [sdd_pkg::AXI_DATA_W-1:0]       rdata,
  output logic [1:0]                           rresp,
  output logic                                 rvalid,
  input  wire logic                            rready,
  input  wire logic                            clk_fail,
  input  wire logic                            fallback_level,
  input  wire logic                            kick_pin,
  output logic                                 dac_out,
  output logic                                 irq
);
  import sdd_pkg::*;

  localparam int AW = AXI_ADDR_W;
  localparam int DW = AXI_DATA_W;

  if (AW < IDX_W + 2) begin : g_bad_addr
    $error("sdd_top: address too narrow for register map");
  end

  // Byte-lane merge of a write into an old word
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_w,
                                          input logic [DW-1:0] new_w,
                                          input logic [3:0]    strb);
    logic [DW-1:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic mapped(input logic [IDX_W-1:0] idx);
    return idx == IDX_ANALOG_CONFIG || idx == IDX_DAC_CODE_VALUE || idx == IDX_SHADOW ||
           idx == IDX_WDCFG || idx == IDX_INTST || idx == IDX_INTMSK ||
           idx == IDX_STATE;
  endfunction

  // Bus channel state
  logic [AW-1:0]    aw_addr_q;
  logic [AW-1:0]    next_aw_addr_q;
  logic             aw_have;
  logic             next_aw_have;
  logic [DW-1:0]    w_data_q;
  logic [DW-1:0]    next_w_data_q;
  logic [3:0]       w_strb_q;
  logic [3:0]       next_w_strb_q;
  logic             w_have;
  logic             next_w_have;
  logic             next_awready;
  logic             next_wready;
  logic             next_bvalid;
  logic [1:0]       next_bresp;
  logic             next_arready;
  logic             next_rvalid;
  logic [1:0]       next_rresp;
  logic [DW-1:0]    next_rdata;
  logic             wr_fire;
  logic [IDX_W-1:0] wr_idx;
  logic [IDX_W-1:0] rd_idx;

  // Block state
  logic [CONFIG_W-1:0] analog_config_register;
  logic [CONFIG_W-1:0] next_analog_config_register;
  logic [VALUE_W-1:0]  dac_code_value;
  logic [VALUE_W-1:0]  next_dac_code_value;
  logic [CONFIG_W-1:0] shadow;
  logic [CONFIG_W-1:0] next_shadow;
  logic              shadow_armed;
  logic              next_shadow_armed;
  logic [KICK_W-1:0] kick_sel;
  logic [KICK_W-1:0] next_kick_sel;
  logic [INT_W-1:0]  int_st;
  logic [INT_W-1:0]  next_int_st;
  logic [INT_W-1:0]  int_msk;
  logic [INT_W-1:0]  next_int_msk;
  sdd_mode_e         mode;
  sdd_mode_e         next_mode;
  logic              kick_prev;
  logic              fail_prev;
  logic              next_dac_out;
  logic              next_irq;
  logic              mod_bit;
  logic              mod_run;
  logic              enabled;
  logic              kick;
  logic              fail_rise;
  logic              val_write;
  logic [DW-1:0]     wr_word;
  logic [DW-1:0]     config_word;
  logic [INT_W-1:0]  int_set;
  logic [INT_W-1:0]  int_clr;

  assign wr_fire = aw_have && w_have && !bvalid;
  assign wr_idx  = aw_addr_q[IDX_W+1:2];
  assign rd_idx  = araddr[IDX_W+1:2];
  assign enabled = !analog_config_register[MODULATOR_DISABLE_BIT];
  assign mod_run = (mode == MODE_RUN);

  // AXI4-Lite channels: address and data taken in either order
  always_comb begin
    next_aw_addr_q = aw_addr_q;
    next_aw_have   = aw_have;
    next_w_data_q  = w_data_q;
    next_w_strb_q  = w_strb_q;
    next_w_have    = w_have;
    next_bvalid    = bvalid;
    next_bresp     = bresp;
    next_rvalid    = rvalid;
    next_rresp     = rresp;
    next_rdata     = rdata;
    if (awvalid && awready) begin
      next_aw_have   = 1'b1;
      next_aw_addr_q = awaddr;
    end
    if (wvalid && wready) begin
      next_w_have   = 1'b1;
      next_w_data_q = wdata;
      next_w_strb_q = wstrb;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_aw_have = 1'b0;
      next_w_have  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      case (rd_idx)
        IDX_ANALOG_CONFIG:  next_rdata = {{(DW-CONFIG_W){1'b0}}, analog_config_register};
        IDX_DAC_CODE_VALUE: next_rdata = {{(DW-VALUE_W){1'b0}}, dac_code_value};
        IDX_SHADOW:         next_rdata = {{(DW-CONFIG_W){1'b0}}, shadow};
        IDX_WDCFG:  next_rdata = {{(DW-KICK_W){1'b0}}, kick_sel};
        IDX_INTST:  next_rdata = {{(DW-INT_W){1'b0}}, int_st};
        IDX_INTMSK: next_rdata = {{(DW-INT_W){1'b0}}, int_msk};
        IDX_STATE:  next_rdata = {{(DW-3){1'b0}}, dac_out, mode};
        default:    next_rdata = '0;
      endcase
    end
    // One write and one read in flight; ready drops while busy
    next_awready = !next_aw_have && !next_bvalid;
    next_wready  = !next_w_have && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q <= '0;
      aw_have   <= 1'b0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      w_have    <= 1'b0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      arready   <= 1'b0;
      rvalid    <= 1'b0;
      rresp     <= RESP_OKAY;
      rdata     <= '0;
    end else begin
      aw_addr_q <= next_aw_addr_q;
      aw_have   <= next_aw_have;
      w_data_q  <= next_w_data_q;
      w_strb_q  <= next_w_strb_q;
      w_have    <= next_w_have;
      awready   <= next_awready;
      wready    <= next_wready;
      bvalid    <= next_bvalid;
      bresp     <= next_bresp;
      arready   <= next_arready;
      rvalid    <= next_rvalid;
      rresp     <= next_rresp;
      rdata     <= next_rdata;
    end
  end

  // Register writes, fallback control and output selection
  always_comb begin
    next_analog_config_register = analog_config_register;
    next_dac_code_value         = dac_code_value;
    next_shadow       = shadow;
    next_shadow_armed = shadow_armed;
    next_kick_sel     = kick_sel;
    next_int_msk      = int_msk;
    int_set           = '0;
    int_clr           = '0;
    val_write         = 1'b0;
    wr_word           = '0;
    config_word       = '0;
    if (wr_fire) begin
      case (wr_idx)
        IDX_DAC_CODE_VALUE: begin
          wr_word   = merge({{(DW-VALUE_W){1'b0}}, dac_code_value}, w_data_q, w_strb_q);
          // Unused low bits stay zero
          next_dac_code_value = {wr_word[VALUE_W-1:CODE_LSB], {CODE_LSB{1'b0}}};
          val_write = 1'b1;
        end
        IDX_SHADOW: begin
          wr_word           = merge({{(DW-CONFIG_W){1'b0}}, shadow}, w_data_q, w_strb_q);
          next_shadow       = wr_word[CONFIG_W-1:0];
          next_shadow_armed = 1'b1;
        end
        IDX_ANALOG_CONFIG: begin
          config_word       = merge({{(DW-CONFIG_W){1'b0}}, analog_config_register},
                                    w_data_q, w_strb_q);
          next_shadow_armed = 1'b0;
          // Guards against a stray write disabling the loop output
          if (shadow_armed && config_word[CONFIG_W-1:0] == ~shadow) begin
            next_analog_config_register = config_word[CONFIG_W-1:0];
          end else begin
            int_set[INT_CONFIG_REFUSED] = 1'b1;
          end
        end
        IDX_WDCFG: begin
          wr_word       = merge({{(DW-KICK_W){1'b0}}, kick_sel}, w_data_q, w_strb_q);
          next_kick_sel = wr_word[KICK_W-1:0];
        end
        IDX_INTST: begin
          wr_word = merge('0, w_data_q, w_strb_q);
          int_clr = wr_word[INT_W-1:0];
        end
        IDX_INTMSK: begin
          wr_word      = merge({{(DW-INT_W){1'b0}}, int_msk}, w_data_q, w_strb_q);
          next_int_msk = wr_word[INT_W-1:0];
        end
        default: begin
          wr_word = '0;
        end
      endcase
    end

    kick      = (kick_pin && !kick_prev) ||
                (kick_sel == KICK_VALUE && val_write);
    fail_rise = clk_fail && !fail_prev;

    case (mode)
      MODE_OFF:      next_mode = enabled ? MODE_RUN : MODE_OFF;
      MODE_RUN:      next_mode = enabled ? MODE_RUN : MODE_OFF;
      MODE_FALLBACK: begin
        if (kick) begin
          next_mode = enabled ? MODE_RUN : MODE_OFF;
        end else begin
          next_mode = MODE_FALLBACK;
        end
      end
      default:       next_mode = MODE_OFF;
    endcase
    // A failure in the same cycle as a kick keeps the output forced
    if (fail_rise) begin
      next_mode = MODE_FALLBACK;
    end

    int_set[INT_CLKFAIL] = fail_rise;
    // A kick beaten by a new failure releases nothing, so it raises no flag
    int_set[INT_KICK]    = kick && mode == MODE_FALLBACK && !fail_rise;
    next_int_st          = (int_st & ~int_clr) | int_set;
    next_irq             = |(next_int_st & next_int_msk);

    case (mode)
      MODE_FALLBACK: next_dac_out = fallback_level;
      MODE_RUN:      next_dac_out = mod_bit;
      default:       next_dac_out = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_config_register <= CONFIG_RESET;
      dac_code_value         <= VALUE_RESET;
      shadow       <= '0;
      shadow_armed <= 1'b0;
      kick_sel     <= KICK_OFF;
      int_st       <= '0;
      int_msk      <= '0;
      mode         <= MODE_OFF;
      kick_prev    <= 1'b0;
      fail_prev    <= 1'b0;
      dac_out      <= 1'b0;
      irq          <= 1'b0;
    end else begin
      analog_config_register <= next_analog_config_register;
      dac_code_value         <= next_dac_code_value;
      shadow       <= next_shadow;
      shadow_armed <= next_shadow_armed;
      kick_sel     <= next_kick_sel;
      int_st       <= next_int_st;
      int_msk      <= next_int_msk;
      mode         <= next_mode;
      kick_prev    <= kick_pin;
      fail_prev    <= clk_fail;
      dac_out      <= next_dac_out;
      irq          <= next_irq;
    end
  end

  sdd_modulator #(
    .CODE_W (CODE_W)
  ) u_mod (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (mod_run),
    .code    (dac_code_value[VALUE_W-1:CODE_LSB]),
    .bit_out (mod_bit)
  );

endmodule // sdd_top

// ==== sim/sdd_monitor.sv ====
// Checker for the DAC control top: bus answers, quiet start, clock-fail fallback.
// Assumes one aclk domain; bound onto every sdd_top.
`timescale 1ns/1ps
module sdd_monitor (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       awvalid,
  input wire logic       awready,
  input wire logic       wvalid,
  input wire logic       wready,
  input wire logic [1:0] bresp,
  input wire logic       bvalid,
  input wire logic       bready,
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic       rvalid,
  input wire logic       clk_fail,
  input wire logic       fallback_level,
  input wire logic       kick_pin,
  input wire logic       dac_out,
  input wire logic       irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Set once software or a failure could have moved the output
  logic seen;
  always_ff @(posedge aclk) begin
    if (!aresetn) seen <= 1'h0;
    else if (bvalid || clk_fail) seen <= 1'h1;
  end
  AST_RESET_QUIET: assert property ($rose(aresetn) |-> !dac_out && !irq && !bvalid)
    else $error("outputs busy right after reset");
  AST_NO_EARLY_OUT: assert property (!seen |-> !dac_out)
    else $error("output moved before any write");
  AST_FAIL_FORCE: assert property ($rose(clk_fail) |-> ##2 dac_out == $past(fallback_level))
    else $error("fallback level not forced");
  AST_FAIL_HOLD: assert property ($rose(clk_fail) ##1
    ($stable(fallback_level) && !$rose(kick_pin) && !bvalid)[*8] |-> dac_out == fallback_level)
    else $error("fallback level not held");
  AST_WR_RESP: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write answer late");
  AST_WR_BLOCK: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer pending");
  AST_B_ONCE: assert property (bvalid && bready |=> !bvalid)
    else $error("write answer repeated");
  AST_RD_RESP: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  AST_RD_BLOCK: assert property (rvalid |-> !arready)
    else $error("read taken while answer pending");
  cover property ($rose(clk_fail));
  cover property (bvalid && bresp == 2'h2);
  cover property ($rose(irq));
endmodule // sdd_monitor

bind sdd_top sdd_monitor i_mon (.*);

// ==== sim/sdd_host.sv ====
// Host model: AXI4-Lite master programming the DAC control registers.
// Assumes its tasks are entered right after a rising aclk edge.
`timescale 1ns/1ps
module sdd_host (
  input  wire logic        aclk,
  output logic [7:0]       awaddr,
  output logic [2:0]       awprot,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic [2:0]       arprot,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  import sdd_pkg::*;
  assign awprot = 3'h0;
  assign arprot = 3'h0;
  assign wstrb  = 4'hF;
  // Held high: every answer is taken at the edge it is seen
  assign bready = 1'h1;
  assign rready = 1'h1;
  initial begin
    awvalid = 1'h0;
    wvalid  = 1'h0;
    arvalid = 1'h0;
    awaddr  = 8'h00;
    araddr  = 8'h00;
    wdata   = 32'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    r = 2'h3;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) begin
        r = bresp;
        break;
      end
    end
    if (n == 64) testbench.hang("write");
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    d = 32'h0;
    r = 2'h3;
    araddr  <= a;
    arvalid <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        break;
      end
    end
    if (n == 64) testbench.hang("read");
  endtask
  // Config writes are refused unless the inverse lands in the shadow first
  task automatic analog_config(input logic [7:0] v);
    logic [1:0] r;
    wr({IDX_SHADOW, 2'h0}, {24'h0, ~v}, r);
    wr({IDX_ANALOG_CONFIG, 2'h0}, {24'h0, v}, r);
  endtask
  task automatic code(input logic [16:0] c);
    logic [1:0] r;
    wr({IDX_DAC_CODE_VALUE, 2'h0}, {8'h0, c, 7'h00}, r);
  endtask
endmodule // sdd_host

// ==== sim/sdd_testbench.sv ====
// Self-checking bench for the sigma-delta DAC control top.
// Assumes sdd_host as bus master and sdd_monitor bound from its own file.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
  import sdd_pkg::*;
  int          miscompares = 0;
  int          compares    = 0;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic        clk_fail = 1'h0;
  logic        fallback_level = 1'h0;
  logic        kick_pin = 1'h0;
  logic [7:0]  awaddr, araddr;
  logic [2:0]  awprot, arprot;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, dac_out, irq;
  logic [31:0] d;
  logic [1:0]  r;
  int          h;
  sdd_top i_dut (.*);
  sdd_host i_host (.*);
  initial forever #5 aclk = ~aclk;
  task automatic highs(input int n);
    h = 0;
    repeat (n) begin
      @(posedge aclk);
      h += (dac_out === 1'h1);
    end
  endtask
  task automatic pulse_fail(input logic lvl);
    fallback_level <= lvl;
    repeat (2) @(posedge aclk);
    clk_fail <= 1'h1;
    repeat (3) @(posedge aclk);
    clk_fail <= 1'h0;
    highs(32);
  endtask
  task automatic t_reset;
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    `CHK("dac_out", 1'h0, dac_out)
    `CHK("irq", 1'h0, irq)
    i_host.rd({IDX_ANALOG_CONFIG, 2'h0}, d, r);
    `CHK("config reset", 32'hFD, d)
    i_host.rd({IDX_DAC_CODE_VALUE, 2'h0}, d, r);
    `CHK("value reset", 32'h0, d)
    i_host.rd({IDX_STATE, 2'h0}, d, r);
    `CHK("state reset", 32'h0, d)
    $display("test reset done");
  endtask
  task automatic t_fields;
    i_host.wr({IDX_DAC_CODE_VALUE, 2'h0}, 32'hFFFFFFFF, r);
    i_host.rd({IDX_DAC_CODE_VALUE, 2'h0}, d, r);
    `CHK("value fields", 32'h00FFFF80, d)
    i_host.wr(8'h80, 32'h0, r);
    `CHK("unmapped bresp", RESP_SLVERR, r)
    i_host.rd(8'h80, d, r);
    `CHK("unmapped rresp", RESP_SLVERR, r)
    i_host.rd({IDX_DAC_CODE_VALUE, 2'h0}, d, r);
    `CHK("value kept", 32'h00FFFF80, d)
    highs(64);
    `CHK("disabled highs", 0, h)
    $display("test fields done");
  endtask
  task automatic t_enable;
    i_host.analog_config(8'hFC);
    i_host.rd({IDX_ANALOG_CONFIG, 2'h0}, d, r);
    `CHK("config enabled", 32'hFC, d)
    i_host.code(17'h10000);
    highs(8);
    highs(256);
    `CHK("half density", 128, h)
    i_host.code(17'h00000);
    highs(8);
    highs(256);
    `CHK("zero density", 0, h)
    $display("test enable done");
  endtask
  task automatic t_refused;
    i_host.wr({IDX_ANALOG_CONFIG, 2'h0}, 32'hFD, r);
    i_host.rd({IDX_ANALOG_CONFIG, 2'h0}, d, r);
    `CHK("config unshadowed", 32'hFC, d)
    i_host.rd({IDX_INTST, 2'h0}, d, r);
    `CHK("refused flag", 32'h4, d & 32'h4)
    `CHK("irq masked", 1'h0, irq)
    i_host.wr({IDX_INTMSK, 2'h0}, 32'h4, r);
    repeat (2) @(posedge aclk);
    `CHK("irq raised", 1'h1, irq)
    i_host.wr({IDX_INTST, 2'h0}, 32'h4, r);
    repeat (2) @(posedge aclk);
    `CHK("irq cleared", 1'h0, irq)
    $display("test refused done");
  endtask
  task automatic t_fallback;
    i_host.code(17'h10000);
    pulse_fail(1'h1);
    `CHK("forced high", 32, h)
    i_host.rd({IDX_STATE, 2'h0}, d, r);
    `CHK("state forced", 32'h6, d)
    kick_pin <= 1'h1;
    repeat (2) @(posedge aclk);
    kick_pin <= 1'h0;
    highs(8);
    highs(256);
    `CHK("pin kick resumes", 128, h)
    i_host.rd({IDX_INTST, 2'h0}, d, r);
    `CHK("fail and kick flags", 32'h3, d & 32'h3)
    i_host.wr({IDX_WDCFG, 2'h0}, {30'h0, KICK_VALUE}, r);
    pulse_fail(1'h0);
    `CHK("forced low", 0, h)
    i_host.code(17'h10000);
    highs(8);
    highs(256);
    `CHK("value kick resumes", 128, h)
    // Left forced so the following reset must release it
    pulse_fail(1'h1);
    `CHK("forced again", 32, h)
    $display("test fallback done");
  endtask
  task automatic hang(input string s);
    miscompares++;
    $display("MISMATCH %s exp answer got timeout", s);
    results();
  endtask
  task automatic results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    t_reset();
    t_fields();
    t_enable();
    t_refused();
    t_fallback();
    t_reset();
    results();
  end
endmodule // testbench
